/* lrs_cmd.sv */
// Text command interpreter for the rise slew rate setting, status and stored setups
`timescale 1ns/1ps
// Functional notes
// RL1 - A rise command with a number stores it as the low-to-high ramp rate
// RL2 - Optional preset prefix and colon accepted; space separates command from number
// RL3 - Rise followed by question mark returns the stored rise rate
// RL4 - Rise and fall rates are held apart; writing one leaves the other
// RL5 - Rise set without a number is invalid and leaves the setting unchanged
// RL6 - Argument resolved to four decimals; finer digits are ignored
// RL7 - Rates above the supported maximum are stored as that maximum
// RL8 - Rates are taken and reported in amperes per microsecond
// RL9 - No-go is flagged while the sinking load is outside the limits
// RL10 - Whole setup saved to and recalled from 150 addressable slots
// RL11 - Status queries report condition; a clear command clears the status
// RL12 - A query after clamping returns the clamped value
module lrs_cmd import lrs_pkg::*; #(
	parameter logic [23:0] RISE_MAX = 24'h03D090,
	parameter logic [23:0] FALL_MAX = 24'h03D090
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Command characters in
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	// Reply characters out
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	// Go/no-go inputs
	input wire logic load_on_i,
	input wire logic [23:0] meas_i,
	input wire lrs_lim_t lim_i,
	// Setup and status out
	output lrs_setup_t setup_o,
	output logic nogo_o,
	output logic err_o
);

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_n;
	logic rst_n;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ****************************************
	// Character classes and decode
	// ****************************************
	lrs_state_t state;
	lrs_cmd_t cmd;
	logic [31:0] word;
	logic [2:0] wlen;
	logic pfx;
	logic [23:0] acc;
	logic got_digit;
	logic [2:0] fd;
	logic dot;
	logic [23:0] conv;
	logic [3:0] pos;
	logic [3:0] digit;
	logic [7:0] tx_byte;
	lrs_setup_t setup;
	logic err;
	logic nogo;
	lrs_setup_t slots [0:149];

	logic [7:0] ch;
	logic fire;
	logic is_letter;
	logic is_digit;
	logic is_term;
	logic is_sp;
	lrs_cmd_t cmd_now;
	logic pfx_ok;
	logic has_arg;
	logic can_query;
	logic idle_err;
	logic num_err;
	logic qend_err;
	logic slot_ok;
	logic apply_err;
	logic err_ev;
	logic clr_ev;
	logic [27:0] acc_mul;
	logic [23:0] acc_next;
	logic [39:0] scaled;
	logic [23:0] rise_val;
	logic [23:0] fall_val;
	logic [7:0] slot_idx;
	logic [23:0] place_p;

	assign rx_ready_o = (state == S_IDLE) || (state == S_NUM) || (state == S_SKIP) ||
		(state == S_QEND);
	assign fire = rx_valid_i && rx_ready_o;
	// Case-insensitive keywords
	assign ch = (rx_data_i >= 8'h61 && rx_data_i <= 8'h7A) ? rx_data_i - 8'h20 : rx_data_i;
	assign is_letter = (ch >= 8'h41 && ch <= 8'h5A) || ch == 8'h2A;
	assign is_digit = ch >= CH_ZERO && ch <= 8'h39;
	assign is_term = ch == CH_SEMI || ch == CH_NL || ch == CH_CR;
	assign is_sp = ch == CH_SP;
	assign cmd_now = lrs_decode(word);
	assign pfx_ok = !pfx && (word == KW_PRES || word == KW_STAT || word == KW_SYST); // [RL2]
	assign has_arg = cmd_now == C_RISE || cmd_now == C_FALL || cmd_now == C_STOR ||
		cmd_now == C_RECA;
	assign can_query = cmd_now == C_RISE || cmd_now == C_FALL || cmd_now == C_NG ||
		cmd_now == C_ERR;
	assign idle_err = state == S_IDLE && fire && ((ch == CH_COLON && !pfx_ok) ||
		(is_sp && wlen != 3'h0 && !has_arg) || (ch == CH_QM && !can_query) ||
		(is_term && wlen != 3'h0 && cmd_now != C_CLR) || // [RL5]
		!(is_letter || ch == CH_COLON || is_sp || ch == CH_QM || is_term));
	assign num_err = state == S_NUM && fire && ((is_term && !got_digit) || // [RL5]
		(ch == CH_DOT && dot) || !(is_digit || ch == CH_DOT || is_sp || is_term));
	assign qend_err = state == S_QEND && fire && !(is_sp || is_term);
	assign slot_ok = !dot && acc != 24'h000000 && acc <= STATE_SLOTS; // [RL10]
	assign apply_err = state == S_APPLY && (cmd == C_STOR || cmd == C_RECA) && !slot_ok;
	assign err_ev = idle_err || num_err || qend_err || apply_err;
	assign clr_ev = state == S_IDLE && fire && is_term && cmd_now == C_CLR; // [RL11]

	// Accumulator saturates so overlong inputs still clamp high
	assign acc_mul = 28'(acc) * 28'h000000A + 28'(ch[3:0]);
	assign acc_next = (acc_mul > 28'(ACC_SAT)) ? ACC_SAT : acc_mul[23:0];
	// Units of 0.0001 A/us; fewer than four decimals are scaled up
	assign scaled = 40'(acc) * 40'(lrs_pow10(3'(FRAC_DIGITS - fd))); // [RL8]
	assign rise_val = (scaled > 40'(RISE_MAX)) ? RISE_MAX : scaled[23:0]; // [RL7]
	assign fall_val = (scaled > 40'(FALL_MAX)) ? FALL_MAX : scaled[23:0];
	assign slot_idx = 8'(acc - 24'h000001);
	assign place_p = lrs_pow10((pos < POS_DOT) ? 3'(4'h6 - pos) : 3'(4'h7 - pos));

	// ****************************************
	// Parser and reply sequencer
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			cmd <= C_NONE;
			word <= 32'h00000000;
			wlen <= 3'h0;
			pfx <= 1'b0;
			acc <= 24'h000000;
			got_digit <= 1'b0;
			fd <= 3'h0;
			dot <= 1'b0;
			conv <= 24'h000000;
			pos <= 4'h0;
			digit <= 4'h0;
			tx_byte <= 8'h00;
		end else begin
			case (state)
				S_IDLE: begin
					if (fire) begin
						if (err_ev) begin
							state <= is_term ? S_IDLE : S_SKIP;
							word <= 32'h00000000;
							wlen <= 3'h0;
							pfx <= 1'b0;
						end else if (is_letter) begin
							if (wlen < 3'h4) begin
								word <= {word[23:0], ch};
								wlen <= wlen + 3'h1;
							end
						end else if (ch == CH_COLON) begin
							pfx <= 1'b1; // [RL2]
							word <= 32'h00000000;
							wlen <= 3'h0;
						end else if (is_sp && wlen != 3'h0) begin
							cmd <= cmd_now;
							acc <= 24'h000000;
							got_digit <= 1'b0;
							fd <= 3'h0;
							dot <= 1'b0;
							state <= S_NUM;
						end else if (ch == CH_QM) begin
							cmd <= cmd_now;
							state <= S_QEND;
						end else if (is_term) begin
							word <= 32'h00000000;
							wlen <= 3'h0;
							pfx <= 1'b0;
						end
					end
				end
				S_NUM: begin
					if (fire) begin
						if (num_err) begin
							state <= is_term ? S_IDLE : S_SKIP;
						end else if (is_digit) begin
							got_digit <= 1'b1;
							// Digits past the fourth decimal are dropped
							if (!dot) begin
								acc <= acc_next;
							end else if (fd < FRAC_DIGITS) begin // [RL6]
								acc <= acc_next;
								fd <= fd + 3'h1;
							end
						end else if (ch == CH_DOT) begin
							dot <= 1'b1;
						end else if (is_term) begin
							state <= S_APPLY;
						end
						if (is_term) begin
							word <= 32'h00000000;
							wlen <= 3'h0;
							pfx <= 1'b0;
						end
					end
				end
				S_SKIP: begin
					if (fire && is_term) begin
						state <= S_IDLE;
						word <= 32'h00000000;
						wlen <= 3'h0;
						pfx <= 1'b0;
					end
				end
				S_QEND: begin
					if (fire && !is_sp) begin
						word <= 32'h00000000;
						wlen <= 3'h0;
						pfx <= 1'b0;
						state <= is_term ? S_CONV : S_SKIP;
						digit <= 4'h0;
						// Snapshot of the stored, already clamped value
						case (cmd)
							C_RISE: conv <= setup.rise; // [RL3] [RL12]
							C_FALL: conv <= setup.fall;
							C_NG: conv <= {23'h000000, nogo}; // [RL11]
							default: conv <= {23'h000000, err};
						endcase
						pos <= (cmd == C_NG || cmd == C_ERR) ? POS_FLAG : 4'h0;
					end
				end
				S_APPLY: begin
					state <= S_IDLE;
				end
				S_CONV: begin
					// One subtraction per cycle; a trade of latency for area
					if (pos == POS_NL) begin
						tx_byte <= CH_NL;
						state <= S_SEND;
					end else if (pos == POS_DOT) begin
						tx_byte <= CH_DOT;
						state <= S_SEND;
					end else if (conv >= place_p) begin
						conv <= conv - place_p;
						digit <= digit + 4'h1;
					end else begin
						tx_byte <= CH_ZERO + {4'h0, digit};
						state <= S_SEND;
					end
				end
				S_SEND: begin
					if (tx_ready_i) begin
						digit <= 4'h0;
						pos <= pos + 4'h1;
						state <= (pos == POS_NL) ? S_IDLE : S_CONV;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	assign tx_valid_o = state == S_SEND;
	assign tx_data_o = tx_byte;

	// ****************************************
	// Setup registers and stored states
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			setup <= '{rise: RATE_RST, fall: RATE_RST};
		end else if (state == S_APPLY) begin
			if (cmd == C_RISE) begin
				setup.rise <= rise_val; // [RL1] [RL4] [RL7]
			end else if (cmd == C_FALL) begin
				setup.fall <= fall_val; // [RL4]
			end else if (cmd == C_RECA && slot_ok) begin
				setup <= slots[slot_idx]; // [RL10]
			end
		end
	end

	// Slots keep no reset, as a non-volatile store would not
	always_ff @(posedge clk_sys_i) begin
		if (state == S_APPLY && cmd == C_STOR && slot_ok) begin
			slots[slot_idx] <= setup; // [RL10]
		end
	end

	assign setup_o = setup;

	// ****************************************
	// Status flags
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			err <= 1'b0;
		end else if (err_ev) begin
			err <= 1'b1;
		end else if (clr_ev) begin
			err <= 1'b0; // [RL11]
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			nogo <= 1'b0;
		end else begin
			nogo <= load_on_i && (meas_i > lim_i.hi || meas_i < lim_i.lo); // [RL9]
		end
	end

	assign err_o = err;
	assign nogo_o = nogo;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n);

	AST_RISE_CAP: assert property (setup.rise <= RISE_MAX) // [RL7]
		else $error("rise rate above maximum");
	AST_RISE_STORE: assert property ((state == S_APPLY && cmd == C_RISE) |=> // [RL1]
		setup.rise == $past(rise_val) && state == S_IDLE)
		else $error("rise value not stored");
	AST_FALL_KEPT: assert property ((state == S_APPLY && cmd == C_RISE) |=> // [RL4]
		$stable(setup.fall))
		else $error("fall changed by rise write");
	AST_NO_NUMBER: assert property ((state == S_NUM && fire && is_term && !got_digit) |=> // [RL5]
		err && $stable(setup) && state == S_IDLE)
		else $error("rise without number accepted");
	AST_FRAC_DROP: assert property ((state == S_NUM && fire && is_digit && dot && // [RL6]
		fd == FRAC_DIGITS && !num_err) |=> $stable(acc))
		else $error("fifth decimal altered value");
	AST_PREFIX: assert property ((state == S_IDLE && fire && ch == CH_COLON && // [RL2]
		word == KW_PRES && !pfx) |=> state == S_IDLE && pfx && wlen == 3'h0)
		else $error("prefix not accepted");
	AST_QUERY_SNAP: assert property ((state == S_QEND && fire && is_term && // [RL3]
		cmd == C_RISE) |=> state == S_CONV && conv == $past(setup.rise) && pos == 4'h0)
		else $error("query does not return stored rise");
	AST_NOGO: assert property ((load_on_i && meas_i > lim_i.hi) |=> nogo_o) // [RL9]
		else $error("no-go not flagged");
	AST_SLOT_RANGE: assert property ((state == S_APPLY && cmd == C_STOR && // [RL10]
		acc > STATE_SLOTS) |=> err_o)
		else $error("bad slot not flagged");
	AST_CLEAR: assert property ((clr_ev && !err_ev) |=> !err_o) // [RL11]
		else $error("clear did not clear status");
	AST_REPLY_LEN: assert property ((state == S_SEND && pos == POS_NL && tx_ready_i) |=> // [RL12]
		state == S_IDLE)
		else $error("reply did not end on newline");

	COV_RISE_SET: cover property (state == S_APPLY && cmd == C_RISE);
	COV_CLAMP: cover property (state == S_APPLY && cmd == C_RISE && scaled > 40'(RISE_MAX));
	COV_RISE_QUERY: cover property (state == S_QEND && fire && is_term && cmd == C_RISE);
	COV_RECALL: cover property (state == S_APPLY && cmd == C_RECA && slot_ok);

endmodule

/* lrs_pkg.sv */
// Package: constants, types and helpers of the rise slew rate command interpreter
package lrs_pkg;

	// ****************************************
	// Widths, characters and counts
	// ****************************************
	localparam int RATE_W = 24;
	localparam logic [2:0] FRAC_DIGITS = 3'h4;
	localparam logic [23:0] STATE_SLOTS = 24'h000096;
	localparam logic [23:0] RATE_RST = 24'h000000;
	localparam logic [23:0] ACC_SAT = 24'hFFFFFF;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_SEMI = 8'h3B;
	localparam logic [7:0] CH_NL = 8'h0A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_QM = 8'h3F;
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [3:0] POS_DOT = 4'h3;
	localparam logic [3:0] POS_NL = 4'h8;
	localparam logic [3:0] POS_FLAG = 4'h7;

	// ****************************************
	// Keywords, first four letters, right aligned
	// ****************************************
	localparam logic [31:0] KW_PRES = 32'h50524553;
	localparam logic [31:0] KW_STAT = 32'h53544154;
	localparam logic [31:0] KW_SYST = 32'h53595354;
	localparam logic [31:0] KW_RISE = 32'h52495345;
	localparam logic [31:0] KW_FALL = 32'h46414C4C;
	localparam logic [31:0] KW_STOR = 32'h53544F52;
	localparam logic [31:0] KW_RECA = 32'h52454341;
	localparam logic [31:0] KW_CLR = 32'h00434C52;
	localparam logic [31:0] KW_NG = 32'h00004E47;
	localparam logic [31:0] KW_ERRO = 32'h4552524F;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_NUM = 3'b001,
		S_SKIP = 3'b010,
		S_QEND = 3'b011,
		S_APPLY = 3'b100,
		S_CONV = 3'b101,
		S_SEND = 3'b110
	} lrs_state_t;

	typedef enum logic [2:0] {
		C_NONE = 3'b000,
		C_RISE = 3'b001,
		C_FALL = 3'b010,
		C_STOR = 3'b011,
		C_RECA = 3'b100,
		C_CLR = 3'b101,
		C_NG = 3'b110,
		C_ERR = 3'b111
	} lrs_cmd_t;

	typedef struct packed {
		logic [23:0] rise;
		logic [23:0] fall;
	} lrs_setup_t;

	typedef struct packed {
		logic [23:0] hi;
		logic [23:0] lo;
	} lrs_lim_t;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [23:0] lrs_pow10(input logic [2:0] e);
		case (e)
			3'h0: lrs_pow10 = 24'h000001;
			3'h1: lrs_pow10 = 24'h00000A;
			3'h2: lrs_pow10 = 24'h000064;
			3'h3: lrs_pow10 = 24'h0003E8;
			3'h4: lrs_pow10 = 24'h002710;
			3'h5: lrs_pow10 = 24'h0186A0;
			3'h6: lrs_pow10 = 24'h0F4240;
			default: lrs_pow10 = 24'h000001;
		endcase
	endfunction

	function automatic lrs_cmd_t lrs_decode(input logic [31:0] w);
		case (w)
			KW_RISE: lrs_decode = C_RISE;
			KW_FALL: lrs_decode = C_FALL;
			KW_STOR: lrs_decode = C_STOR;
			KW_RECA: lrs_decode = C_RECA;
			KW_CLR: lrs_decode = C_CLR;
			KW_NG: lrs_decode = C_NG;
			KW_ERRO: lrs_decode = C_ERR;
			default: lrs_decode = C_NONE;
		endcase
	endfunction

endpackage

/* lrs_host.sv */
// Remote host model: sends command lines and collects reply characters
`timescale 1ns/1ps
module lrs_host (
	// Clock
	input wire logic clk_sys_i,
	// Command characters to the interpreter
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	input wire logic rx_ready_i,
	// Reply characters from the interpreter
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o
);
	// ****************************************
	// Reply sink
	// ****************************************
	logic slow = 1'b0;
	logic [1:0] cnt = 2'h0;
	logic [7:0] reply [$];
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
	end
	// Slow mode accepts one edge in four, to stretch the reply
	always @(posedge clk_sys_i) begin
		cnt <= cnt + 2'h1;
		tx_ready_o <= !slow || (cnt == 2'h3);
	end
	// Both settled at the falling edge and held to the taking edge
	always @(negedge clk_sys_i) begin
		if (tx_valid_i && tx_ready_o) begin
			reply.push_back(tx_data_i);
		end
	end
	// ****************************************
	// Command sender
	// ****************************************
	// Keyword, space and number in the units the device expects
	task automatic send(input string s);
		logic r;
		reply.delete();
		for (int i = 0; i < s.len(); i++) begin
			rx_valid_o <= 1'b1;
			rx_data_o <= s[i];
			do begin
				@(negedge clk_sys_i);
				r = rx_ready_i;
				@(posedge clk_sys_i);
			end while (!r);
		end
		rx_valid_o <= 1'b0;
		// Released line shows no stale character
		rx_data_o <= ~rx_data_o;
	endtask
endmodule

/* lrs_cmd_tb.sv */
// Self-checking testbench of the rise slew rate command interpreter
`timescale 1ns/1ps
module lrs_cmd_tb import lrs_pkg::*;;
	// ****************************************
	// Signals
	// ****************************************
	localparam logic [23:0] MAX = 24'h03D090;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic rx_valid, rx_ready, tx_valid, tx_ready, nogo, err;
	logic load_on = 1'b0;
	logic [7:0] rx_data;
	logic [7:0] tx_data;
	logic [23:0] meas = 24'h000000;
	lrs_lim_t lim = '0;
	lrs_setup_t setup;
	int fail_count = 0;
	int compares = 0;
	always #10 clk_sys_i = ~clk_sys_i;
	lrs_cmd #(.RISE_MAX(MAX), .FALL_MAX(MAX)) dut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
		.tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
		.load_on_i(load_on), .meas_i(meas), .lim_i(lim),
		.setup_o(setup), .nogo_o(nogo), .err_o(err)
	);
	lrs_host host (
		.clk_sys_i(clk_sys_i),
		.rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_ready_i(rx_ready),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready)
	);
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic stop_test();
		if (fail_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// Setup lands one edge after the terminator is taken
	task automatic line(input string s);
		host.send(s);
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic reply(input string q, input string exp);
		string got;
		int n;
		got = "";
		n = 0;
		host.send(q);
		while ((host.reply.size() == 0 || host.reply[$] !== CH_NL) && n < 400) begin
			@(posedge clk_sys_i);
			n++;
		end
		foreach (host.reply[i]) got = {got, string'(host.reply[i])};
		compares++;
		if (got != exp) begin
			fail_count++;
			$display("BAD %0t reply to %s wrong", $time, q);
		end
		repeat (2) @(posedge clk_sys_i);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_set();
		chk(setup, 48'h0, "setup after reset");
		chk({nogo, err, tx_valid}, 48'h0, "flags after reset");
		line("RISE 1.5;");
		chk(setup.rise, 24'h003A98, "plain set");
		line("PRES:RISE 2.12345;");
		chk(setup.rise, 24'h0052F2, "prefixed, fifth decimal");
		line("PRESET:RISE 0.0001\n");
		chk(setup.rise, 24'h000001, "smallest step");
	endtask
	task automatic t_indep();
		line("FALL 3;");
		chk(setup, {24'h000001, 24'h007530}, "fall write");
		line("RISE 7;");
		chk(setup, {24'h011170, 24'h007530}, "rise write");
	endtask
	task automatic t_nonum();
		line("RISE;");
		chk(err, 1'b1, "missing number flagged");
		chk(setup.rise, 24'h011170, "missing number kept");
		reply("ERROR?;", "1\n");
		line("CLR;");
		chk(err, 1'b0, "clear");
		line("RISE ;");
		chk(setup, {24'h011170, 24'h007530}, "space only kept");
		reply("STAT:ERROR?;", "1\n");
		line("CLR;");
	endtask
	task automatic t_clamp();
		host.slow = 1'b1;
		line("RISE 99.5;");
		chk(setup.rise, MAX, "clamped");
		reply("RISE?;", "025.0000\n");
		host.slow = 1'b0;
	endtask
	task automatic t_query();
		line("RISE 1.5;");
		reply("rise?\015", "001.5000\n");
		reply("PRES:FALL?;", "003.0000\n");
	endtask
	task automatic t_nogo();
		logic [23:0] m [5] = '{24'h000201, 24'h000200, 24'h0000FF, 24'h000100, 24'h000300};
		logic on;
		lim <= '{hi: 24'h000200, lo: 24'h000100};
		for (int i = 0; i < 5; i++) begin
			on = (i != 4);
			load_on <= on;
			meas <= m[i];
			@(posedge clk_sys_i);
			@(negedge clk_sys_i);
			chk(nogo, on && (m[i] > 24'h000200 || m[i] < 24'h000100), "no-go");
			@(posedge clk_sys_i);
		end
		load_on <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		reply("STAT:NG?;", "1\n");
		load_on <= 1'b0;
	endtask
	task automatic t_store();
		line("STOR 150;");
		line("RISE 9;");
		line("FALL 2;");
		line("SYST:RECALL 150;");
		chk(setup, {24'h003A98, 24'h007530}, "recall top slot");
		chk(err, 1'b0, "top slot legal");
		line("STOR 151;");
		chk(err, 1'b1, "slot out of range");
		line("CLR;");
	endtask
	// ****************************************
	// Sequence and watchdog
	// ****************************************
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		t_set();
		t_indep();
		t_nonum();
		t_clamp();
		t_query();
		t_nogo();
		t_store();
		stop_test();
	end
	initial begin
		#400000;
		fail_count++;
		stop_test();
	end
endmodule
